// [hw/brg_pkg.sv]
// constants, timing counts and state codes shared by the repeater guard
package brg_pkg;

	// =====================================================================
	// clock and printed times
	localparam int CLK_MHZ = 40;
	localparam int T_JABBER_NS = 228700;
	localparam int T_STABLE_NS = 2000;
	localparam int T_GAP_MIN_NS = 2000;
	localparam int T_GAP_MAX_NS = 4000;
	localparam int T_LATENCY_NS = 1000;
	localparam int T_EDGE_MIN_NS = 250;

	// =====================================================================
	// derived cycle counts (least times round up, the edge limit rounds down)
	localparam int JABBER_CYC = (T_JABBER_NS * CLK_MHZ + 999) / 1000;
	localparam int STABLE_CYC = (T_STABLE_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_MIN_CYC = (T_GAP_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_MAX_CYC = (T_GAP_MAX_NS * CLK_MHZ + 999) / 1000;
	localparam int EDGE_MIN_CYC = (T_EDGE_MIN_NS * CLK_MHZ) / 1000;

	// =====================================================================
	// sample buffer shape: sample period is the latency cycles over depth, rounded down
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 2;
	localparam int LATENCY_CYC = (T_LATENCY_NS * CLK_MHZ) / 1000;
	localparam int SAMPLE_DIV = LATENCY_CYC / FIFO_DEPTH;
	localparam int CNT8_MAX = 255;

	// =====================================================================
	// reset values
	localparam logic DIR_RST = 1'b0;
	localparam logic DRV_RST = 1'b0;
	localparam logic ISO_RST = 1'b0;

	// =====================================================================
	// forwarding states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FWD = 3'b010,
		ST_HOLD = 3'b100
	} brg_state_t;

endpackage

// [hw/brg_fifo.sv]
// sample buffer with valid/ready on both sides and a flush
`timescale 1ns/1ps
`default_nettype none
module brg_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// occupancy
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [$clog2(DEPTH+1)-1:0] FULL_LVL = ($clog2(DEPTH+1))'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_idx_r;
	logic [AW-1:0] rd_idx_r;
	logic [$clog2(DEPTH+1)-1:0] level_r;
	logic push;
	logic pop;

	assign in_ready = (level_r != FULL_LVL);
	assign out_valid = (level_r != '0);
	assign out_data = mem_r[rd_idx_r];
	assign level = level_r;
	assign push = in_valid && in_ready && !flush;
	assign pop = out_valid && out_ready && !flush;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_idx_r] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_idx_r <= '0;
			rd_idx_r <= '0;
			level_r <= '0;
		end else if (flush) begin
			wr_idx_r <= '0;
			rd_idx_r <= '0;
			level_r <= '0;
		end else begin
			if (push) begin
				wr_idx_r <= (wr_idx_r == LAST_IDX) ? '0 : wr_idx_r + 1'b1;
			end
			if (pop) begin
				rd_idx_r <= (rd_idx_r == LAST_IDX) ? '0 : rd_idx_r + 1'b1;
			end
			if (push && !pop) begin
				level_r <= level_r + 1'b1;
			end else if (pop && !push) begin
				level_r <= level_r - 1'b1;
			end
		end
	end
endmodule // brg_fifo
`default_nettype wire

// [hw/brg_seg_mon.sv]
// per-segment line watcher: stability, jabber time and misplaced edges
`timescale 1ns/1ps
`default_nettype none
module brg_seg_mon #(
	parameter int JAB_CYC = brg_pkg::JABBER_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// received line
	input wire logic rx_act,
	input wire logic rx_data,
	// line state
	output logic stable,
	output logic jab,
	output logic glitch
);
	import brg_pkg::*;
	localparam int JW = $clog2(JAB_CYC + 1);
	localparam logic [7:0] STABLE_LIM = 8'(STABLE_CYC);
	localparam logic [7:0] EDGE_LIM = 8'(EDGE_MIN_CYC);
	localparam logic [7:0] CNT_SAT = 8'(CNT8_MAX);
	localparam logic [JW-1:0] JAB_LIM = JW'(JAB_CYC);

	logic prev_act_r;
	logic prev_data_r;
	logic [7:0] still_r;
	logic [7:0] edge_r;
	logic [JW-1:0] on_r;
	logic change;
	logic data_edge;

	assign change = (rx_act != prev_act_r) || (rx_data != prev_data_r);
	assign data_edge = rx_act && prev_act_r && (rx_data != prev_data_r);
	assign stable = (still_r == STABLE_LIM) && !rx_act;
	assign jab = rx_act && (on_r == JAB_LIM - 1'b1);
	assign glitch = data_edge && (edge_r < EDGE_LIM);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prev_act_r <= 1'b0;
			prev_data_r <= 1'b0;
		end else begin
			prev_act_r <= rx_act;
			prev_data_r <= rx_data;
		end
	end

	// quiet time since the last change of the line
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			still_r <= '0;
		end else if (change) begin
			still_r <= '0;
		end else if (still_r != STABLE_LIM) begin
			still_r <= still_r + 1'b1;
		end
	end

	// continuous transmit time, saturating past the jabber limit
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			on_r <= '0;
		end else if (!rx_act) begin
			on_r <= '0;
		end else if (on_r != JAB_LIM) begin
			on_r <= on_r + 1'b1;
		end
	end

	// spacing between data transitions inside a frame
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			edge_r <= CNT_SAT;
		end else if (data_edge) begin
			edge_r <= '0;
		end else if (edge_r != CNT_SAT) begin
			edge_r <= edge_r + 1'b1;
		end
	end
endmodule // brg_seg_mon
`default_nettype wire

// [hw/brg_repeater.sv]
// two-segment repeater direction control, jabber guard and forwarding buffer
`timescale 1ns/1ps
`default_nettype none
module brg_repeater #(
	parameter int JAB_CYC = brg_pkg::JABBER_CYC,
	parameter int DEPTH = brg_pkg::FIFO_DEPTH,
	parameter int WIDTH = brg_pkg::FIFO_WIDTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// segment 1 line
	input wire logic seg1_rx_act,
	input wire logic seg1_rx_data,
	output logic seg1_tx_data,
	output logic seg1_tx_oe_n,
	// segment 2 line
	input wire logic seg2_rx_act,
	input wire logic seg2_rx_data,
	output logic seg2_tx_data,
	output logic seg2_tx_oe_n,
	// status
	output logic seg1_isolated,
	output logic seg2_isolated,
	output logic seg1_collision,
	output logic seg2_collision,
	output brg_pkg::brg_state_t fwd_state
);
	import brg_pkg::*;
	localparam int LW = $clog2(DEPTH + 1);
	localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);
	localparam logic [3:0] DIV_LAST = 4'(SAMPLE_DIV - 1);
	localparam logic [7:0] GAP_LIM = 8'(GAP_MAX_CYC);

	// =====================================================================
	// line watchers
	logic stable1;
	logic stable2;
	logic jab1;
	logic jab2;
	logic glitch1;
	logic glitch2;

	brg_seg_mon #(.JAB_CYC(JAB_CYC)) u_mon1 (
		.clock(clock),
		.rst(rst),
		.rx_act(seg1_rx_act),
		.rx_data(seg1_rx_data),
		.stable(stable1),
		.jab(jab1),
		.glitch(glitch1)
	);

	brg_seg_mon #(.JAB_CYC(JAB_CYC)) u_mon2 (
		.clock(clock),
		.rst(rst),
		.rx_act(seg2_rx_act),
		.rx_data(seg2_rx_data),
		.stable(stable2),
		.jab(jab2),
		.glitch(glitch2)
	);

	// =====================================================================
	// direction state
	brg_state_t state_r;
	logic dir_r;
	logic iso1_r;
	logic iso2_r;
	logic drv1_r;
	logic drv2_r;
	logic dat1_r;
	logic dat2_r;
	logic primed_r;
	logic col1_r;
	logic col2_r;
	logic [3:0] div_r;
	logic [7:0] quiet_r;

	logic src_act;
	logic src_data;
	logic src_jab;
	logic src_stable;
	logic dest_drv;
	logic strb;
	logic flush;
	logic wr_valid;
	logic wr_ready;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;
	logic [LW-1:0] level;
	logic gap_ok;

	assign src_act = dir_r ? seg2_rx_act : seg1_rx_act;
	assign src_data = dir_r ? seg2_rx_data : seg1_rx_data;
	assign src_jab = dir_r ? jab2 : jab1;
	assign src_stable = dir_r ? stable2 : stable1;
	assign dest_drv = dir_r ? drv1_r : drv2_r;
	assign strb = (div_r == DIV_LAST);
	assign gap_ok = (quiet_r == GAP_LIM);
	// a jabbering source drops everything buffered so the output stops at once
	assign flush = (state_r == ST_FWD) && src_jab;
	// only the owning segment is sampled; the other side is not listened to
	assign wr_valid = (state_r == ST_FWD) && strb && !src_jab;
	// a fresh output waits out the turnaround gap unless the buffer is full
	assign rd_ready = strb && (primed_r || state_r == ST_HOLD)
		&& (gap_ok || dest_drv || level == FULL_LVL);

	// =====================================================================
	// sample period; a full buffer stretches it rather than dropping a sample
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_r <= '0;
		end else if (wr_valid && !wr_ready) begin
			div_r <= div_r;
		end else if (strb) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	brg_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
		.clock(clock),
		.rst(rst),
		.flush(flush),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data({src_act, src_data}),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data),
		.level(level)
	);

	// =====================================================================
	// direction control
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			dir_r <= DIR_RST;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (seg1_rx_act && !iso1_r) begin
						state_r <= ST_FWD;
						dir_r <= 1'b0;
					end else if (seg2_rx_act && !iso2_r) begin
						state_r <= ST_FWD;
						dir_r <= 1'b1;
					end
				end
				ST_FWD: begin
					if (src_jab || !src_act) begin
						state_r <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					// keep the direction until drained and the source line is quiet
					if (!rd_valid && !dest_drv && src_stable) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// =====================================================================
	// isolation; the jabber set wins, idle line releases
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			iso1_r <= ISO_RST;
			iso2_r <= ISO_RST;
		end else begin
			if (jab1) begin
				iso1_r <= 1'b1;
			end else if (!seg1_rx_act) begin
				iso1_r <= 1'b0;
			end
			if (jab2) begin
				iso2_r <= 1'b1;
			end else if (!seg2_rx_act) begin
				iso2_r <= 1'b0;
			end
		end
	end

	// =====================================================================
	// output start gate: buffer filled to depth, or the source frame ended (ST_HOLD), before first read
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			primed_r <= 1'b0;
		end else if (state_r == ST_IDLE || flush) begin
			primed_r <= 1'b0;
		end else if (level == FULL_LVL) begin
			primed_r <= 1'b1;
		end
	end

	// quiet time on both outputs since the last driven sample
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			quiet_r <= GAP_LIM;
		end else if (drv1_r || drv2_r) begin
			quiet_r <= '0;
		end else if (!gap_ok) begin
			quiet_r <= quiet_r + 1'b1;
		end
	end

	// =====================================================================
	// line drivers: replay raw samples, so a damaged frame passes as received
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			drv1_r <= DRV_RST;
			drv2_r <= DRV_RST;
			dat1_r <= 1'b0;
			dat2_r <= 1'b0;
		end else if (flush) begin
			drv1_r <= 1'b0;
			drv2_r <= 1'b0;
		end else if (rd_valid && rd_ready) begin
			if (dir_r) begin
				drv1_r <= rd_data[1];
				dat1_r <= rd_data[0];
			end else begin
				drv2_r <= rd_data[1];
				dat2_r <= rd_data[0];
			end
		end else if (!rd_valid && state_r == ST_HOLD) begin
			drv1_r <= 1'b0;
			drv2_r <= 1'b0;
		end
	end

	// collision flags: misplaced edge on the source, or traffic while driving
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			col1_r <= 1'b0;
			col2_r <= 1'b0;
		end else begin
			col1_r <= (glitch1 && state_r == ST_FWD && !dir_r) || (seg1_rx_act && drv1_r);
			col2_r <= (glitch2 && state_r == ST_FWD && dir_r) || (seg2_rx_act && drv2_r);
		end
	end

	assign seg1_tx_data = dat1_r;
	assign seg2_tx_data = dat2_r;
	assign seg1_tx_oe_n = !drv1_r;
	assign seg2_tx_oe_n = !drv2_r;
	assign seg1_isolated = iso1_r;
	assign seg2_isolated = iso2_r;
	assign seg1_collision = col1_r;
	assign seg2_collision = col2_r;
	assign fwd_state = state_r;

	// =====================================================================
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_jab_sets_iso: assert property (jab1 |=> iso1_r)
		else $error("segment 1 not isolated after jabber");
	a_iso_blocks_start: assert property (iso1_r && state_r == ST_IDLE |=> !(state_r == ST_FWD && !dir_r))
		else $error("isolated segment 1 took direction");
	a_jab_cuts_out: assert property (state_r == ST_FWD && !dir_r && jab1 |=> !drv2_r [*3])
		else $error("output not cut after jabber");
	a_cut_no_sof: assert property (state_r == ST_FWD && dir_r && jab2 |=> state_r == ST_HOLD && !drv1_r)
		else $error("jabbering segment 2 still forwarded");
	a_latency_start: assert property ($rose(drv2_r) |-> $past(level, 1) != '0 && $past(primed_r || state_r == ST_HOLD))
		else $error("output started before the buffer primed");
	a_one_dir: assert property (!(drv1_r && drv2_r))
		else $error("both segments driven");
	a_src_not_driven: assert property (state_r == ST_FWD && !dir_r |-> !drv1_r)
		else $error("source segment driven during forwarding");
	a_hold_stable: assert property (state_r == ST_HOLD && !src_stable |=> state_r != ST_IDLE)
		else $error("direction released before line stable");
	a_gap_delay: assert property ($rose(drv1_r || drv2_r) |-> $past(quiet_r, 1) == GAP_LIM || $past(level) == FULL_LVL)
		else $error("second frame not held for the gap");
	a_glitch_col: assert property (glitch2 && state_r == ST_FWD && dir_r |=> seg2_collision)
		else $error("misplaced edge not flagged");
	a_iso_release: assert property (iso2_r && !seg2_rx_act && !jab2 |=> !iso2_r)
		else $error("isolation not released on idle line");

	c_fwd_12: cover property (state_r == ST_FWD && !dir_r ##[1:200] drv2_r);
	c_fwd_21: cover property (state_r == ST_FWD && dir_r ##[1:200] drv1_r);
	c_jab_cut: cover property (flush);
	c_dest_col: cover property (seg2_rx_act && drv2_r);
	c_gap_wait: cover property (primed_r && !gap_ok && !dest_drv && level != FULL_LVL);
endmodule // brg_repeater
`default_nettype wire

// [dv/brg_seg_model.sv]
// one bus segment as seen by the repeater: a device sending frames on command
`timescale 1ns/1ps
`default_nettype none
module brg_seg_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// frame command
	input wire logic go,
	input wire logic [15:0] len,
	input wire logic delim,
	input wire logic glt,
	// line towards the repeater
	output logic rx_act,
	output logic rx_data
);
	// =====================================================================
	// frame timing
	logic [15:0] left_r;
	logic [15:0] pos_r;
	logic last_r;
	logic bit_v;
	always_comb begin
		// bits last 16 cycles; optional delimiter is a long high; optional one-cycle misplaced pulse
		bit_v = ((delim && pos_r < 16'h0018) ? 1'b1 : pos_r[4]) ^ (glt && pos_r == 16'h0028);
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			left_r <= 16'h0000;
			pos_r <= 16'h0000;
			last_r <= 1'b0;
		end else if (go && left_r == 16'h0000) begin
			left_r <= len;
			pos_r <= 16'h0000;
		end else if (left_r != 16'h0000) begin
			left_r <= left_r - 16'h0001;
			pos_r <= pos_r + 16'h0001;
			last_r <= ~bit_v;
		end
	end
	// released line shows the inverse of the last bit, never a stale copy
	assign rx_act = (left_r != 16'h0000);
	assign rx_data = rx_act ? bit_v : last_r;
endmodule // brg_seg_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the two-segment repeater guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import brg_pkg::*;
	// =====================================================================
	// clock, reset, wiring
	localparam int JB = 300;
	localparam int LIMIT = 20000;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic go1 = 1'b0, go2 = 1'b0, dl = 1'b0, gl = 1'b0, clr = 1'b0;
	logic [15:0] len1 = 16'h0000, len2 = 16'h0000;
	logic a1, d1, a2, d2, t1, oe1, t2, oe2, iso1, iso2, col1, col2;
	brg_state_t st;
	int miscompares = 0, samples_checked = 0, cyc = 0;
	always #12.5 clock = ~clock;
	brg_seg_model m1 (.clock(clock), .rst(rst), .go(go1), .len(len1), .delim(dl), .glt(gl), .rx_act(a1), .rx_data(d1));
	brg_seg_model m2 (.clock(clock), .rst(rst), .go(go2), .len(len2), .delim(dl), .glt(gl), .rx_act(a2), .rx_data(d2));
	brg_repeater #(.JAB_CYC(JB)) uut (.clock(clock), .rst(rst), .seg1_rx_act(a1), .seg1_rx_data(d1),
		.seg1_tx_data(t1), .seg1_tx_oe_n(oe1), .seg2_rx_act(a2), .seg2_rx_data(d2), .seg2_tx_data(t2),
		.seg2_tx_oe_n(oe2), .seg1_isolated(iso1), .seg2_isolated(iso2), .seg1_collision(col1),
		.seg2_collision(col2), .fwd_state(st));
	// =====================================================================
	// output monitor: latency, driven cycles, sticky flags
	logic [15:0] t_r, lat1_r, lat2_r, drv1_r, drv2_r;
	logic c1_r, c2_r, i1_r, i2_r;
	always_ff @(posedge clock) begin
		if (clr) begin
			t_r <= 16'h0000;
			drv1_r <= 16'h0000;
			drv2_r <= 16'h0000;
			lat1_r <= 16'hFFFF;
			lat2_r <= 16'hFFFF;
			{c1_r, c2_r, i1_r, i2_r} <= 4'h0;
		end else begin
			t_r <= t_r + 16'h0001;
			if (oe1 === 1'b0) begin
				drv1_r <= drv1_r + 16'h0001;
				if (drv1_r == 16'h0000) lat1_r <= t_r;
			end
			if (oe2 === 1'b0) begin
				drv2_r <= drv2_r + 16'h0001;
				if (drv2_r == 16'h0000) lat2_r <= t_r;
			end
			c1_r <= c1_r | (col1 === 1'b1);
			c2_r <= c2_r | (col2 === 1'b1);
			i1_r <= i1_r | (iso1 === 1'b1);
			i2_r <= i2_r | (iso2 === 1'b1);
		end
	end
	// data transitions replayed while a segment is driven
	logic [15:0] e1_r, e2_r;
	logic [1:0] w1_r, w2_r;
	always_ff @(posedge clock) begin
		w1_r <= {oe1, t1};
		w2_r <= {oe2, t2};
		if (clr) begin
			e1_r <= 16'h0000;
			e2_r <= 16'h0000;
		end else begin
			if (oe1 === 1'b0 && w1_r[1] === 1'b0 && t1 !== w1_r[0]) e1_r <= e1_r + 16'h0001;
			if (oe2 === 1'b0 && w2_r[1] === 1'b0 && t2 !== w2_r[0]) e2_r <= e2_r + 16'h0001;
		end
	end
	// =====================================================================
	// compare and report
	task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		samples_checked++;
		if (((got >= lo) !== 1'b1) || ((got <= hi) !== 1'b1)) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == LIMIT) begin
			miscompares++;
			report_and_stop;
		end
	end
	// =====================================================================
	// stimulus helpers
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic clear_mon;
		@(posedge clock) clr <= 1'b1;
		@(posedge clock) clr <= 1'b0;
	endtask
	task automatic start(input int s, input logic [15:0] n, input logic d, input logic g);
		@(posedge clock);
		dl <= d;
		gl <= g;
		if (s == 1) begin
			len1 <= n;
			go1 <= 1'b1;
		end else begin
			len2 <= n;
			go2 <= 1'b1;
		end
		@(posedge clock);
		go1 <= 1'b0;
		go2 <= 1'b0;
	endtask
	task automatic check_fwd(input int s, input logic [15:0] n, input logic [15:0] ne);
		logic [15:0] drv, lat, back;
		drv = (s == 1) ? drv2_r : drv1_r;
		lat = (s == 1) ? lat2_r : lat1_r;
		back = (s == 1) ? drv1_r : drv2_r;
		chk_rng(drv, n - 16'd4, n + 16'd4);
		chk_rng(lat, 16'(2 * FIFO_DEPTH), 16'(LATENCY_CYC + 4));
		chk_eq(back, 16'h0000);
		chk_eq({14'h0000, i1_r, i2_r}, 16'h0000);
		chk_eq((s == 1) ? e2_r : e1_r, ne);
	endtask
	// =====================================================================
	// ordinary frames as table rows
	typedef struct {int s; logic [15:0] n; logic [15:0] e;} brg_row_t;
	brg_row_t rows [3] = '{'{1, 16'd100, 16'd6}, '{2, 16'd100, 16'd6}, '{1, 16'd250, 16'd15}};
	initial begin
		idle(8);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		chk_eq({12'h000, oe1, oe2, t1, t2}, 16'h000C);
		chk_eq({12'h000, iso1, iso2, col1, col2}, 16'h0000);
		chk_eq(16'(st), 16'(ST_IDLE));
		$display("test reset done");
		idle(200);
		foreach (rows[i]) begin
			clear_mon;
			start(rows[i].s, rows[i].n, 1'b0, 1'b0);
			idle(rows[i].n + 250);
			check_fwd(rows[i].s, rows[i].n, rows[i].e);
			$display("test row %0d done", i);
		end
		// overlong frame is cut and the segment isolated: segment 1 plain, segment 2 with delimiter
		for (int d = 0; d < 2; d++) begin
			clear_mon;
			start(d + 1, 16'd400, d[0], 1'b0);
			idle(560);
			chk_rng(d ? drv1_r : drv2_r, 16'(JB - 2 * FIFO_DEPTH - 8), 16'(JB));
			chk_eq({15'h0000, (d ? i2_r : i1_r)}, 16'h0001);
			chk_eq({15'h0000, (d ? iso2 : iso1)}, 16'h0000);
			clear_mon;
			start(d + 1, 16'd100, 1'b0, 1'b0);
			idle(350);
			check_fwd(d + 1, 16'd100, 16'd6);
			$display("test jabber %0d done", d);
		end
		// both segments answer: first one wins, collision on the other
		clear_mon;
		start(1, 16'd100, 1'b0, 1'b0);
		idle(48);
		start(2, 16'd100, 1'b0, 1'b0);
		idle(350);
		chk_eq({15'h0000, c2_r}, 16'h0001);
		chk_eq(drv1_r, 16'h0000);
		chk_rng(drv2_r, 16'd96, 16'd104);
		chk_eq(e2_r, 16'd6);
		$display("test collision done");
		// reverse frame too soon after the end is not taken, 3 us later it is
		for (int k = 0; k < 2; k++) begin
			clear_mon;
			start(1, 16'd100, 1'b0, 1'b0);
			idle(k == 0 ? 140 : 218);
			clear_mon;
			start(2, k == 0 ? 16'd15 : 16'd100, 1'b0, 1'b0);
			idle(350);
			if (k == 0) begin
				chk_eq(drv1_r, 16'h0000);
			end else begin
				chk_rng(drv1_r, 16'd96, 16'd104);
				chk_rng(lat1_r, 16'(2 * FIFO_DEPTH), 16'(2 * FIFO_DEPTH + GAP_MAX_CYC - GAP_MIN_CYC));
			end
			$display("test turnaround %0d done", k);
		end
		// misplaced edge flags a collision on the source and still passes the frame
		for (int s = 1; s < 3; s++) begin
			clear_mon;
			start(s, 16'd100, 1'b0, 1'b1);
			idle(350);
			chk_eq({15'h0000, ((s == 1) ? c1_r : c2_r)}, 16'h0001);
			chk_rng((s == 1) ? drv2_r : drv1_r, 16'd96, 16'd104);
			$display("test glitch %0d done", s);
		end
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
